/* File: core/rdsbr_block_ram.sv */
`timescale 1ns/1ps
// circular store of decoded blocks; a write into a full store is dropped
// so the oldest unread blocks are never overwritten
module rdsbr_block_ram
#(
  parameter int DEPTH = rdsbr_pkg::BUF_DEPTH,
  parameter int W     = rdsbr_pkg::BLK_W
)
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_srst,
  input  wire logic                     i_clear,
  input  wire logic                     i_wr,
  input  wire logic [W-1:0]             i_wdata,
  input  wire logic                     i_rd,
  output logic      [W-1:0]             o_rdata,
  output logic      [$clog2(DEPTH+1)-1:0] o_count,
  output logic                          o_dropped
);
  import rdsbr_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;

  wire full   = (o_count == FULL);
  wire empty  = (o_count == '0);
  wire do_wr  = i_wr && !full;          // RULE7 RULE8
  wire do_rd  = i_rd && !empty;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign o_rdata = mem[rp];

  // storage array carries no reset
  always_ff @(posedge i_ref_clk)
  begin
    if (do_wr)
      mem[wp] <= i_wdata;               // RULE1
  end

  // pointers, fill level and drop pulse
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_clear)
    begin
      wp        <= '0;
      rp        <= '0;
      o_count   <= '0;
      o_dropped <= 1'b0;
    end
    else
    begin
      if (do_wr)
        wp <= wrap_inc(wp);
      if (do_rd)
        rp <= wrap_inc(rp);
      o_count   <= o_count + CW'(do_wr) - CW'(do_rd);
      o_dropped <= i_wr && full;
    end
  end
endmodule

/* File: core/rdsbr_pkg.sv */
package rdsbr_pkg;

  // clock and time base
  localparam int CLK_MHZ        = 40;
  localparam int PAUSE_NS       = 265000;   // forced-high pause after a readout
  localparam int PAUSE_CYC      = (PAUSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PAUSE_CNT_W    = 16;

  // hold guarantees the buffer depth gives the controller
  localparam int HOLD_EMPTY_MS  = 480;      // first block after an empty buffer
  localparam int HOLD_PEND_MS   = 20;       // block left over after a pause
  localparam int SELECT_MAX_MS  = 20;       // longest select-high period

  // buffer shape
  localparam int BUF_DEPTH      = 24;
  localparam int BLK_W          = 16;
  localparam int FLAG_W         = 2;        // empty flag, full flag

  // serial address phase
  localparam int ADDR_W         = 8;
  localparam int ADDR_CNT_W     = 4;
  localparam int OUT_CNT_W      = 5;
  // readout address code; value is arbitrary
  localparam logic [ADDR_W-1:0] OUT_ADDR = 8'h5a;

  // synchronised pin indices
  localparam int PIN_N          = 3;
  localparam int PIN_SEL        = 0;
  localparam int PIN_CLK        = 1;
  localparam int PIN_DAT        = 2;

  // request line state machine
  typedef enum logic [3:0]
  {
    ST_HOLD  = 4'b0001,
    ST_REQ   = 4'b0010,
    ST_READ  = 4'b0100,
    ST_PAUSE = 4'b1000
  } rdsbr_state_type;

endpackage

/* File: core/rdsbr_read_request.sv */
`timescale 1ns/1ps
//
// Behaviour
// [RULE1] An on-chip buffer keeps up to 24 decoded blocks awaiting readout.
// [RULE2] Storing a complete block raises a read request by pulling the line low.
// [RULE3] After each readout the line is forced high for 265 us from select low.
// [RULE4] With nothing left unread the line stays high until a new block lands.
// [RULE5] With blocks still unread the line goes low as soon as the pause ends.
// [RULE6] After a sync reset the line stays high until sync, then goes low.
// [RULE7] Data announced after an empty buffer survives 480 ms unread.
// [RULE8] Data announced at the end of a pause survives 20 ms unread.
// [RULE9] The controller may read many blocks per select but ends it in 20 ms.
// [RULE10] A readout with no pending request returns all zero bits.
// [RULE11] On a shared line the controller tells sources apart by timing.
// [RULE12] The controller should judge fill from the flags, not the line level.
// [RULE13] No serial transfer is taken or answered before the oscillator runs.
// [RULE14] The pause counter restarts on each select falling edge of a readout.
module rdsbr_read_request
#(
  parameter int DEPTH     = rdsbr_pkg::BUF_DEPTH,
  parameter int PAUSE_CYC = rdsbr_pkg::PAUSE_CYC
)
(
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_srst,
  input  wire logic                       i_osc_running,
  input  wire logic                       i_sync_reset,
  input  wire logic                       i_sync_ok,
  input  wire logic                       i_blk_wr,
  input  wire logic [rdsbr_pkg::BLK_W-1:0] i_blk_data,
  input  wire logic                       i_select,
  input  wire logic                       i_serial_shift_clock,
  input  wire logic                       i_serial_input_line,
  output logic                            o_do_out,
  output logic                            o_do_oe,
  output logic [$clog2(DEPTH+1)-1:0]      o_buffer_count,
  output logic                            o_blk_dropped
);
  import rdsbr_pkg::*;

  localparam int CW = $clog2(DEPTH+1);
  localparam int OW = BLK_W + FLAG_W;
  localparam logic [CW-1:0] FULL_LVL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_LVL  = CW'(1);
  localparam logic [PAUSE_CNT_W-1:0] PAUSE_LOAD =
    PAUSE_CNT_W'(PAUSE_CYC - 1);
  localparam logic [ADDR_CNT_W-1:0] ADDR_LAST = ADDR_CNT_W'(ADDR_W - 1);
  localparam logic [OUT_CNT_W-1:0]  OUT_LAST  = OUT_CNT_W'(OW - 1);

  // pin synchronisers: stage one feeds stage two only
  logic [PIN_N-1:0] pin_s1;
  logic [PIN_N-1:0] pin_s2;
  logic [PIN_N-1:0] pin_s3;
  logic [PIN_N-1:0] pin_f;
  logic [PIN_N-1:0] pin_q;

  rdsbr_state_type        state;
  rdsbr_state_type        next_state;
  logic [PAUSE_CNT_W-1:0] pause_cnt;
  logic                   pending;     // request was low when select rose
  logic                   addr_done;
  logic                   out_mode;
  logic [ADDR_CNT_W-1:0]  addr_cnt;
  logic [ADDR_W-1:0]      addr_sh;
  logic [OUT_CNT_W-1:0]   out_left;
  logic [OW-1:0]          out_sh;
  logic                   do_bit;
  logic                   word_real;   // loaded word came from the buffer
  logic [BLK_W-1:0]       head;
  logic [CW-1:0]          count;
  logic                   dropped;

  // a pin change is taken only once stages two and three agree
  function automatic logic [PIN_N-1:0] agree(
    input logic [PIN_N-1:0] a,
    input logic [PIN_N-1:0] b,
    input logic [PIN_N-1:0] prev);
    agree = (a & b) | (prev & (a | b));
  endfunction

  // serial side is held off until the oscillator runs
  wire sel_rise  = i_osc_running && pin_f[PIN_SEL] && !pin_q[PIN_SEL];
  wire sel_fall  = pin_q[PIN_SEL] && !pin_f[PIN_SEL];
  wire clk_rise  = pin_f[PIN_CLK] && !pin_q[PIN_CLK];
  wire clk_fall  = pin_q[PIN_CLK] && !pin_f[PIN_CLK];
  wire in_read   = (state == ST_READ);                  // RULE13
  wire addr_step = in_read && !addr_done && clk_rise;
  wire addr_hit  = addr_step && (addr_cnt == ADDR_LAST)
                   && ({pin_f[PIN_DAT], addr_sh[ADDR_W-1:1]} == OUT_ADDR);
  wire out_step  = in_read && out_mode && clk_fall;
  wire need_word = out_step && (out_left == '0);
  wire have_data = pending && (count != '0);
  // pop only once bit 0 of a real word is taken; the closing falling clock
  // of a frame loads a word that may never be read, so loading must not pop
  wire last_take = in_read && out_mode && clk_rise && (out_left == '0);
  wire pop       = last_take && word_real;
  wire pause_end = (pause_cnt == '0);
  wire can_req   = i_sync_ok && (count != '0);

  // flags tell the controller how much is left after this block
  wire [OW-1:0] word = have_data
    ? {count == ONE_LVL, count == FULL_LVL, head}
    : '0;                                              // RULE10

  rdsbr_block_ram #(.DEPTH(DEPTH), .W(BLK_W)) u_ram
  (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_clear   (i_sync_reset),
    .i_wr      (i_blk_wr),
    .i_wdata   (i_blk_data),
    .i_rd      (pop),
    .o_rdata   (head),
    .o_count   (count),
    .o_dropped (dropped)
  );

  // request state: low while unread data is announced, high otherwise
  always_comb
  begin
    next_state = state;
    case (state)
      ST_HOLD:
        if (sel_rise)
          next_state = ST_READ;
        else if (can_req)
          next_state = ST_REQ;                         // RULE2 RULE6
      ST_REQ:
        if (sel_rise)
          next_state = ST_READ;
      ST_READ:
        if (sel_fall)
          next_state = ST_PAUSE;                       // RULE3
      ST_PAUSE:
        if (sel_rise)
          next_state = ST_READ;
        else if (pause_end)
          next_state = can_req ? ST_REQ : ST_HOLD;     // RULE4 RULE5
      default:
        next_state = ST_HOLD;
    endcase
  end

  // pin sampling, three stages deep
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f  <= '0;
      pin_q  <= '0;
    end
    else
    begin
      pin_s1 <= {i_serial_input_line, i_serial_shift_clock, i_select};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= agree(pin_s2, pin_s3, pin_f);
      pin_q  <= pin_f;
    end
  end

  // a sync reset drops back to holding the line high
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_sync_reset)
      state <= ST_HOLD;                                // RULE6
    else
      state <= next_state;
  end

  // pause timer, reloaded on every select fall that ends a readout
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      pause_cnt <= '0;
    else if (in_read && sel_fall)
      pause_cnt <= PAUSE_LOAD;                         // RULE14
    else if (state == ST_PAUSE && !pause_end)
      pause_cnt <= pause_cnt - 1'b1;                   // RULE3
  end

  // address phase: lsb first on rising shift clock
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || sel_rise)
    begin
      addr_cnt  <= '0;
      addr_sh   <= '0;
      addr_done <= 1'b0;
      out_mode  <= 1'b0;
      pending   <= (state == ST_REQ);
    end
    else if (addr_step)
    begin
      addr_sh   <= {pin_f[PIN_DAT], addr_sh[ADDR_W-1:1]};
      addr_cnt  <= addr_cnt + 1'b1;
      addr_done <= (addr_cnt == ADDR_LAST);
      out_mode  <= addr_hit;
    end
  end

  // data phase: msb first, next bit on each falling shift clock;
  // blocks follow back to back for as long as select stays high
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || sel_rise)
    begin
      out_left  <= '0;
      out_sh    <= '0;
      do_bit    <= 1'b1;
      word_real <= 1'b0;
    end
    else if (need_word)
    begin
      do_bit    <= word[OW-1];
      out_sh    <= {word[OW-2:0], 1'b0};
      out_left  <= OUT_LAST;
      word_real <= have_data;
    end
    else if (out_step)
    begin
      do_bit   <= out_sh[OW-1];
      out_sh   <= {out_sh[OW-2:0], 1'b0};
      out_left <= out_left - 1'b1;
    end
    else if (pop)
      word_real <= 1'b0;
  end

  // open-drain line: enable pulls low; data during readout, else request
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_do_out       <= 1'b0;
      o_do_oe        <= 1'b0;
      o_buffer_count <= '0;
      o_blk_dropped  <= 1'b0;
    end
    else
    begin
      o_do_out       <= 1'b0;
      o_do_oe        <= in_read ? (out_mode && !do_bit)
                                : (state == ST_REQ);   // RULE2 RULE4
      o_buffer_count <= count;
      o_blk_dropped  <= dropped;                       // RULE7 RULE8
    end
  end
endmodule

/* File: tb/rdsbr_ctrl_model.sv */
`timescale 1ns/1ps
// far-side controller; shift clock idles low between frames
module rdsbr_ctrl_model
#(
  parameter int HALF = 4  // half period in clocks: 200 ns shift clock
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_line,
  output logic      o_select,
  output logic      o_sck,
  output logic      o_sdi
);
  logic [17:0] words[$];
  // idle levels
  initial
  begin
    o_select = 1'b0;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // one readout of up to n words; select stays far under 20 ms
  task automatic read(input int n, input logic [7:0] addr);
    logic [17:0] w;
    words.delete();
    o_select <= 1'b1;
    hold(2 * HALF);
    for (int i = 0; i < 8; i++)
    begin
      o_sdi <= addr[i];
      hold(HALF);
      o_sck <= 1'b1;
      hold(HALF);
      o_sck <= 1'b0;
    end
    for (int k = 0; k < n; k++)
    begin
      for (int b = 17; b >= 0; b--)
      begin
        hold(HALF);
        o_sck <= 1'b1;
        hold(HALF);
        w[b] = i_line; // late in the high phase: pin path lags ~6 clocks
        o_sck <= 1'b0;
        o_sdi <= !o_sdi; // released input keeps moving
      end
      words.push_back(w);
      if (w[17])
        break;
    end
    hold(HALF);
    o_select <= 1'b0;
  endtask
endmodule

/* File: tb/rdsbr_read_request_properties.sv */
`timescale 1ns/1ps
// request line timing tied to its causes at the inputs
module rdsbr_read_request_properties
#(
  parameter int DEPTH     = 24,
  parameter int PAUSE_CYC = 40
)
(
  input wire logic                       i_ref_clk,
  input wire logic                       i_srst,
  input wire logic                       i_osc_running,
  input wire logic                       i_sync_reset,
  input wire logic                       i_sync_ok,
  input wire logic                       i_select,
  input wire logic                       o_do_oe,
  input wire logic [$clog2(DEPTH+1)-1:0] o_buffer_count,
  input wire logic                       o_blk_dropped
);
  localparam int PMAX = PAUSE_CYC + 12;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic [15:0] sel_cnt;
  logic        armed;
  // cycles since select was high; the pin path lag is why checks skip 8
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || i_select)
      sel_cnt <= '0;
    else if (sel_cnt != 16'hffff)
      sel_cnt <= sel_cnt + 16'h0001;
    if (i_srst || i_sync_reset)
      armed <= 1'b0;
    else if (i_select)
      armed <= i_osc_running;   // a select without oscillator starts no pause
  end
  property p_reset;
    $fell(i_srst) |-> !o_do_oe && o_buffer_count == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("line low after reset");
  property p_depth;
    o_buffer_count <= DEPTH;
  endproperty
  a_depth: assert property (p_depth) else $error("fill over depth");
  property p_cause;
    sel_cnt >= 8 && $rose(o_do_oe) |-> o_buffer_count != '0 && i_sync_ok;
  endproperty
  a_cause: assert property (p_cause) else $error("request w/o data");
  property p_pause;
    armed && sel_cnt >= 8 && sel_cnt < PAUSE_CYC |-> !o_do_oe;
  endproperty
  a_pause: assert property (p_pause) else $error("pause cut short");
  property p_relow;
    armed && sel_cnt == PMAX && o_buffer_count != '0 && i_sync_ok |-> o_do_oe;
  endproperty
  a_relow: assert property (p_relow) else $error("no request");
  property p_empty;
    sel_cnt >= 8 && o_buffer_count == '0 |-> !o_do_oe;
  endproperty
  a_empty: assert property (p_empty) else $error("request when empty");
  property p_sync;
    i_sync_reset && !i_sync_ok && sel_cnt >= 8 ##1 (!i_sync_ok)[*4]
      |-> !o_do_oe;
  endproperty
  a_sync: assert property (p_sync) else $error("request before sync");
  property p_drop;
    o_blk_dropped |-> o_buffer_count == DEPTH;
  endproperty
  a_drop: assert property (p_drop) else $error("drop when not full");
  property p_osc;
    (!i_osc_running && i_select)[*8] |-> $stable(o_do_oe) &&
      $stable(o_buffer_count);
  endproperty
  a_osc: assert property (p_osc) else $error("transfer w/o osc");
  c_req: cover property ($rose(o_do_oe));
  c_drop: cover property (o_blk_dropped);
  c_relow: cover property (armed && sel_cnt == PMAX && o_do_oe);
endmodule

/* File: tb/rdsbr_read_request_test.sv */
`timescale 1ns/1ps
module rdsbr_read_request_test;
  import rdsbr_pkg::*;
  localparam int P = 40;
  logic i_ref_clk, i_srst, i_osc_running, i_sync_reset, i_sync_ok, i_blk_wr;
  logic sel, sck, sdi, o_do_out, o_do_oe, o_blk_dropped;
  logic [BLK_W-1:0] i_blk_data, lfsr, q[$];
  logic [$clog2(BUF_DEPTH+1)-1:0] o_buffer_count;
  int n_fail, n_compared;
  rdsbr_read_request #(.PAUSE_CYC(P)) dut_u (.i_ref_clk, .i_srst,
    .i_osc_running, .i_sync_reset, .i_sync_ok, .i_blk_wr, .i_blk_data,
    .i_select(sel), .i_serial_shift_clock(sck), .i_serial_input_line(sdi),
    .o_do_out, .o_do_oe, .o_buffer_count, .o_blk_dropped);
  rdsbr_ctrl_model ctrl_u (.i_ref_clk, .i_line(!o_do_oe), .o_select(sel),
    .o_sck(sck), .o_sdi(sdi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // next value of the stimulus shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // random block; a store into a full buffer is expected to be lost
  task automatic put;
    lfsr = lfsr_next(lfsr);
    i_blk_wr <= 1'b1;
    i_blk_data <= lfsr;
    if (q.size() < BUF_DEPTH)
      q.push_back(lfsr);
    cyc(1);
    i_blk_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic wait_req(input logic v);
    for (int t = 0; t < 20 && o_do_oe !== v; t++)
      cyc(1);
    check(o_do_oe, v);
  endtask
  // word = empty flag, full flag, data
  function automatic logic [17:0] exp_word(input logic [15:0] d,
    input logic e, input logic f);
    return {e, f, d};
  endfunction
  task automatic read_cmp(input int n, input logic full);
    logic [15:0] d;
    ctrl_u.read(n, OUT_ADDR);
    check(ctrl_u.words.size(), n);
    foreach (ctrl_u.words[k])
    begin
      d = q.pop_front();
      check(ctrl_u.words[k], exp_word(d, q.size() == 0, full && k == 0));
    end
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  // watchdog: a hang counts as a failure
  initial
  begin
    cyc(20000);
    n_fail++;
    results();
  end
  // main sequence
  initial
  begin
    {i_srst, i_osc_running, i_sync_ok} = 3'b111;
    {i_sync_reset, i_blk_wr} = 2'b00;
    i_blk_data = '0;
    lfsr = 16'h81fb;
    cyc(10);
    i_srst <= 1'b0;
    cyc(20);
    ctrl_u.read(2, OUT_ADDR);
    foreach (ctrl_u.words[k])
      check(ctrl_u.words[k], 0);
    cyc(P / 2);
    check(o_do_oe, 1'b0);
    cyc(P + 20);
    repeat (3) put();
    wait_req(1'b1);
    check(o_do_out, 1'b0);
    read_cmp(1, 1'b0);
    cyc(P / 2);
    check(o_do_oe, 1'b0);
    cyc(P);
    check(o_do_oe, 1'b1);
    read_cmp(2, 1'b0);
    cyc(P + 20);
    check(o_do_oe, 1'b0);
    repeat (BUF_DEPTH + 1) put();
    cyc(1);
    check(o_blk_dropped, 1'b1);
    cyc(3);
    check(o_buffer_count, BUF_DEPTH);
    read_cmp(BUF_DEPTH, 1'b1);
    cyc(P + 20);
    put();
    wait_req(1'b1);
    i_osc_running <= 1'b0;
    ctrl_u.read(1, OUT_ADDR);
    cyc(10);
    check(o_buffer_count, 1);
    i_osc_running <= 1'b1;
    cyc(2);
    read_cmp(1, 1'b0);
    cyc(P + 20);
    put();
    wait_req(1'b1);
    i_sync_reset <= 1'b1;
    i_sync_ok <= 1'b0;
    cyc(1);
    i_sync_reset <= 1'b0;
    q.delete();
    cyc(10);
    check(o_do_oe, 1'b0);
    check(o_buffer_count, 0);
    i_sync_ok <= 1'b1;
    put();
    wait_req(1'b1);
    read_cmp(1, 1'b0);
    cyc(P + 20);
    results();
  end
endmodule
bind rdsbr_read_request rdsbr_read_request_properties
  #(.DEPTH(DEPTH), .PAUSE_CYC(PAUSE_CYC)) chk_u (.i_ref_clk, .i_srst,
  .i_osc_running, .i_sync_reset, .i_sync_ok, .i_select, .o_do_oe,
  .o_buffer_count, .o_blk_dropped);
